/* File: src/pio_ctrl_consts.vh */
// Summary of operation
// - thirty-two lines, one bit per register
// - pull-up enable clears, disable sets status
// - pull-up writes act in any configuration
// - pull-up status resets to zero, pulls on
// - own enable/disable set/clear controller ownership
// - unmuxed lines ignore ownership writes, read one
// - ownership reset value is per-line parameter
// - A-select clears, B-select sets choice bit
// - choice steers output only, input to both
// - choice status resets to zero, peripheral A
// - choice writes apply regardless of ownership
// - peripheral-owned pin driven by chosen peripheral
// - output enable/disable set/clear drive status
// - set/clear output data sets/clears level
// - drive and level update under peripheral ownership
// - direct data write changes only masked bits
// - mask enable/disable set/clear, resets zero
// - register writes need no sampling enable
// - sampling and change flags only when enabled
// - change sets flag, masked OR, read clears
// - level status holds last sample when stopped
// - multi-drive line only pulls low, else released
`ifndef PARALLEL_IO_CTRL_CONSTS_VH
`define PARALLEL_IO_CTRL_CONSTS_VH

// -----------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------
`define OFS_OWN_EN      8'h00
`define OFS_OWN_DIS     8'h04
`define OFS_OWN_STAT    8'h08
`define OFS_OUT_EN      8'h10
`define OFS_OUT_DIS     8'h14
`define OFS_OUT_STAT    8'h18
`define OFS_SET_DATA    8'h30
`define OFS_CLR_DATA    8'h34
`define OFS_DATA_STAT   8'h38
`define OFS_PIN_LEVEL   8'h3C
`define OFS_IRQ_EN      8'h40
`define OFS_IRQ_DIS     8'h44
`define OFS_IRQ_MASK    8'h48
`define OFS_IRQ_STAT    8'h4C
`define OFS_MD_EN       8'h50
`define OFS_MD_DIS      8'h54
`define OFS_MD_STAT     8'h58
`define OFS_PU_DIS      8'h60
`define OFS_PU_EN       8'h64
`define OFS_PU_STAT     8'h68
`define OFS_SEL_A       8'h70
`define OFS_SEL_B       8'h74
`define OFS_SEL_STAT    8'h78
`define OFS_WM_EN       8'hA0
`define OFS_WM_DIS      8'hA4
`define OFS_WM_STAT     8'hA8

// -----------------------------------------------------------------------
// reset values and responses
// -----------------------------------------------------------------------
`define RST_ZERO        32'h00000000
`define RST_OWN         32'hFFFFFFFF
`define MUX_LINES       32'hFFFFFFFF
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: src/parallel_io_ctrl.v */
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "pio_ctrl_consts.vh"

module parallel_io_ctrl #(
	parameter [31:0] MUX_LINES_P = `MUX_LINES, // lines with a peripheral
	parameter [31:0] OWN_RESET_P = `RST_OWN    // ownership reset per line
) (
	// clock and reset
	input  wire        REF_CLK_I,
	input  wire        RESET_N_I,
	// sampling clock enable from the power manager
	input  wire        CLK_EN_I,
	// axi4-lite write address and data
	input  wire        AXI_AWVALID_I,
	output wire        AXI_AWREADY_O,
	input  wire [7:0]  AXI_AWADDR_I,
	input  wire        AXI_WVALID_I,
	output wire        AXI_WREADY_O,
	input  wire [31:0] AXI_WDATA_I,
	input  wire [3:0]  AXI_WSTRB_I,
	// axi4-lite write response
	output wire        AXI_BVALID_O,
	input  wire        AXI_BREADY_I,
	output wire [1:0]  AXI_BRESP_O,
	// axi4-lite read
	input  wire        AXI_ARVALID_I,
	output wire        AXI_ARREADY_O,
	input  wire [7:0]  AXI_ARADDR_I,
	output wire        AXI_RVALID_O,
	input  wire        AXI_RREADY_I,
	output wire [31:0] AXI_RDATA_O,
	output wire [1:0]  AXI_RRESP_O,
	// pads
	input  wire [31:0] PIN_IN_I,
	output wire [31:0] PIN_OUT_O,
	output wire [31:0] PIN_OE_O,
	output wire [31:0] PULLUP_EN_O,
	// peripheral a
	input  wire [31:0] PERA_OUT_I,
	input  wire [31:0] PERA_OE_I,
	output wire [31:0] PERA_IN_O,
	// peripheral b
	input  wire [31:0] PERB_OUT_I,
	input  wire [31:0] PERB_OE_I,
	output wire [31:0] PERB_IN_O,
	// change interrupt
	output wire        IRQ_O
);

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	reg        awready_q;     // write address slot free
	reg        wready_q;      // write data slot free
	reg        bvalid_q;      // write response pending
	reg [1:0]  bresp_q;       // write response code
	reg        arready_q;     // read slot free
	reg        rvalid_q;      // read data pending
	reg [31:0] rdata_q;       // read data
	reg [1:0]  rresp_q;       // read response code
	reg [7:0]  waddr_q;       // held write address
	reg [31:0] wdata_q;       // held write data
	reg [3:0]  wstrb_q;       // held byte strobes

	reg [31:0] own_q;         // ctrl_own_status raw bits
	reg [31:0] choice_q;      // periph_choice_status
	reg [31:0] oen_q;         // out_enable_status
	reg [31:0] odata_q;       // out_data_status
	reg [31:0] wmask_q;       // sync_write_mask_status
	reg [31:0] puoff_q;       // pullup_off_status
	reg [31:0] md_q;          // multidrive status
	reg [31:0] imask_q;       // change_irq_mask
	reg [31:0] istat_q;       // change_irq_status
	reg [31:0] level_q;       // pin_level_status

	reg [31:0] pin_out_q;     // registered pad level
	reg [31:0] pin_oe_q;      // registered pad enable
	reg [31:0] pera_in_q;     // pad level to peripheral a
	reg [31:0] perb_in_q;     // pad level to peripheral b
	reg        irq_q;         // registered interrupt line
	reg [31:0] pullup_en_q;   // registered pull-up enables

	// -------------------------------------------------------------------
	// write decode helpers
	// -------------------------------------------------------------------
	wire        do_write;     // both halves held, response slot free
	wire [31:0] bmask;        // byte lanes expanded to bits
	wire [31:0] wv;           // data with disabled lanes zeroed
	wire        do_read;      // read address accepted this cycle
	wire        rd_istat;     // read of the change status register

	assign do_write = !awready_q && !wready_q && !bvalid_q;
	assign bmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
	                   {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wv       = wdata_q & bmask;
	assign do_read  = AXI_ARVALID_I && arready_q;
	assign rd_istat = do_read && (AXI_ARADDR_I == `OFS_IRQ_STAT);

	// per-register write strobes
	wire w_own_en  = do_write && (waddr_q == `OFS_OWN_EN);
	wire w_own_dis = do_write && (waddr_q == `OFS_OWN_DIS);
	wire w_out_en  = do_write && (waddr_q == `OFS_OUT_EN);
	wire w_out_dis = do_write && (waddr_q == `OFS_OUT_DIS);
	wire w_set     = do_write && (waddr_q == `OFS_SET_DATA);
	wire w_clr     = do_write && (waddr_q == `OFS_CLR_DATA);
	wire w_direct  = do_write && (waddr_q == `OFS_DATA_STAT);
	wire w_irq_en  = do_write && (waddr_q == `OFS_IRQ_EN);
	wire w_irq_dis = do_write && (waddr_q == `OFS_IRQ_DIS);
	wire w_md_en   = do_write && (waddr_q == `OFS_MD_EN);
	wire w_md_dis  = do_write && (waddr_q == `OFS_MD_DIS);
	wire w_pu_dis  = do_write && (waddr_q == `OFS_PU_DIS);
	wire w_pu_en   = do_write && (waddr_q == `OFS_PU_EN);
	wire w_sel_a   = do_write && (waddr_q == `OFS_SEL_A);
	wire w_sel_b   = do_write && (waddr_q == `OFS_SEL_B);
	wire w_wm_en   = do_write && (waddr_q == `OFS_WM_EN);
	wire w_wm_dis  = do_write && (waddr_q == `OFS_WM_DIS);

	// unmuxed lines always report controller ownership
	wire [31:0] own_eff = own_q | ~MUX_LINES_P;

	// level change between two successive samples
	wire [31:0] change = CLK_EN_I ? (PIN_IN_I ^ level_q) :
	                     `RST_ZERO;

	// -------------------------------------------------------------------
	// axi write channel: address and data taken in either order
	// -------------------------------------------------------------------
	always @(posedge REF_CLK_I) begin
		if (!RESET_N_I) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
			waddr_q   <= 8'h00;
			wdata_q   <= `RST_ZERO;
			wstrb_q   <= 4'h0;
		end else begin
			// hold the address until the write is carried out
			if (AXI_AWVALID_I && awready_q) begin
				waddr_q   <= AXI_AWADDR_I;
				awready_q <= 1'b0;
			end
			// hold the data likewise
			if (AXI_WVALID_I && wready_q) begin
				wdata_q  <= AXI_WDATA_I;
				wstrb_q  <= AXI_WSTRB_I;
				wready_q <= 1'b0;
			end
			// respond once both halves are in hand
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_known(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end
			// slots reopen only after the response is taken
			if (bvalid_q && AXI_BREADY_I) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// writable offsets; status registers other than direct data are
	// read-only and answer an error on write
	function wr_known;
		input [7:0] a;
		begin
			wr_known = (a == `OFS_OWN_EN)  || (a == `OFS_OWN_DIS) ||
			           (a == `OFS_OUT_EN)  || (a == `OFS_OUT_DIS) ||
			           (a == `OFS_SET_DATA) || (a == `OFS_CLR_DATA) ||
			           (a == `OFS_DATA_STAT) || (a == `OFS_IRQ_EN) ||
			           (a == `OFS_IRQ_DIS) || (a == `OFS_MD_EN) ||
			           (a == `OFS_MD_DIS)  || (a == `OFS_PU_DIS) ||
			           (a == `OFS_PU_EN)   || (a == `OFS_SEL_A) ||
			           (a == `OFS_SEL_B)   || (a == `OFS_WM_EN) ||
			           (a == `OFS_WM_DIS);
		end
	endfunction

	// -------------------------------------------------------------------
	// configuration registers: set/clear pairs, zero bits untouched; direct data write sets and clears masked bits
	// -------------------------------------------------------------------
	// writes here never look at CLK_EN_I, so configuration works with
	// the sampling clock stopped
	always @(posedge REF_CLK_I) begin
		if (!RESET_N_I) begin
			own_q    <= OWN_RESET_P;
			choice_q <= `RST_ZERO;
			oen_q    <= `RST_ZERO;
			odata_q  <= `RST_ZERO;
			wmask_q  <= `RST_ZERO;
			puoff_q  <= `RST_ZERO;
			md_q     <= `RST_ZERO;
			imask_q  <= `RST_ZERO;
		end else begin
			// ownership only moves on muxed lines
			if (w_own_en)
				own_q <= own_q | (wv & MUX_LINES_P);
			else if (w_own_dis)
				own_q <= own_q & ~(wv & MUX_LINES_P);
			// peripheral choice whatever the ownership
			if (w_sel_b)
				choice_q <= choice_q | wv;
			else if (w_sel_a)
				choice_q <= choice_q & ~wv;
			// drive status kept even under peripheral ownership
			if (w_out_en)
				oen_q <= oen_q | wv;
			else if (w_out_dis)
				oen_q <= oen_q & ~wv;
			// output level: set, clear, or masked direct write
			if (w_set)
				odata_q <= odata_q | wv;
			else if (w_clr)
				odata_q <= odata_q & ~wv;
			else if (w_direct)
				odata_q <= (odata_q & ~(wmask_q & bmask)) |
				           (wdata_q & wmask_q & bmask);
			// direct-write mask
			if (w_wm_en)
				wmask_q <= wmask_q | wv;
			else if (w_wm_dis)
				wmask_q <= wmask_q & ~wv;
			// pull-up: status one means pull-up off
			if (w_pu_dis)
				puoff_q <= puoff_q | wv;
			else if (w_pu_en)
				puoff_q <= puoff_q & ~wv;
			// open-drain selection
			if (w_md_en)
				md_q <= md_q | wv;
			else if (w_md_dis)
				md_q <= md_q & ~wv;
			// change interrupt mask
			if (w_irq_en)
				imask_q <= imask_q | wv;
			else if (w_irq_dis)
				imask_q <= imask_q & ~wv;
		end
	end

	// -------------------------------------------------------------------
	// sampling, change flags and interrupt
	// -------------------------------------------------------------------
	// a change seen in the same cycle as the clearing read survives
	always @(posedge REF_CLK_I) begin
		if (!RESET_N_I) begin
			level_q <= `RST_ZERO;
			istat_q <= `RST_ZERO;
			irq_q   <= 1'b0;
		end else begin
			// level status freezes while sampling is stopped
			if (CLK_EN_I)
				level_q <= PIN_IN_I;
			// read clears all, a new change wins
			if (rd_istat)
				istat_q <= change;
			else
				istat_q <= istat_q | change;
			// masked OR; gated so nothing rises while stopped
			irq_q <= CLK_EN_I &&
			         |((rd_istat ? change : (istat_q | change)) &
			           imask_q);
		end
	end

	// -------------------------------------------------------------------
	// pad and peripheral multiplexing
	// -------------------------------------------------------------------
	// peripheral side chosen bit by bit
	wire [31:0] per_oe  = (choice_q & PERB_OE_I) |
	                      (~choice_q & PERA_OE_I);
	wire [31:0] per_out = (choice_q & PERB_OUT_I) |
	                      (~choice_q & PERA_OUT_I);
	// owner picks drive and level
	wire [31:0] src_oe  = (own_eff & oen_q) | (~own_eff & per_oe);
	wire [31:0] src_out = (own_eff & odata_q) | (~own_eff & per_out);

	// registered pads; open-drain lines drive only a low
	always @(posedge REF_CLK_I) begin
		if (!RESET_N_I) begin
			pin_out_q <= `RST_ZERO;
			pin_oe_q  <= `RST_ZERO;
			pera_in_q <= `RST_ZERO;
			perb_in_q <= `RST_ZERO;
			pullup_en_q <= 32'hFFFFFFFF;
		end else begin
			pin_oe_q  <= (md_q & src_oe & ~src_out) |
			             (~md_q & src_oe);
			pin_out_q <= ~md_q & src_out;
			// input goes to both peripherals, unfiltered
			pera_in_q <= PIN_IN_I;
			perb_in_q <= PIN_IN_I;
			// pull-ups follow the status one cycle late, like the pads,
			// so the pin stays a clean flip-flop output
			pullup_en_q <= ~puoff_q;
		end
	end

	// -------------------------------------------------------------------
	// axi read channel
	// -------------------------------------------------------------------
	reg [31:0] rd_val;      // decoded read value
	reg        rd_ok;       // address is mapped
	always @* begin
		rd_val = `RST_ZERO;
		rd_ok  = 1'b1;
		// set/clear registers fall to the wr_known branch and read zero
		if (AXI_ARADDR_I == `OFS_OWN_STAT)
			rd_val = own_eff;
		else if (AXI_ARADDR_I == `OFS_OUT_STAT)
			rd_val = oen_q;
		else if (AXI_ARADDR_I == `OFS_DATA_STAT)
			rd_val = odata_q;
		else if (AXI_ARADDR_I == `OFS_PIN_LEVEL)
			rd_val = level_q;
		else if (AXI_ARADDR_I == `OFS_IRQ_MASK)
			rd_val = imask_q;
		else if (AXI_ARADDR_I == `OFS_IRQ_STAT)
			rd_val = istat_q;
		else if (AXI_ARADDR_I == `OFS_MD_STAT)
			rd_val = md_q;
		else if (AXI_ARADDR_I == `OFS_PU_STAT)
			rd_val = puoff_q;
		else if (AXI_ARADDR_I == `OFS_SEL_STAT)
			rd_val = choice_q;
		else if (AXI_ARADDR_I == `OFS_WM_STAT)
			rd_val = wmask_q;
		else if (wr_known(AXI_ARADDR_I))
			rd_val = `RST_ZERO;
		else
			rd_ok = 1'b0;
	end

	// one read in flight; data one cycle after address
	always @(posedge REF_CLK_I) begin
		if (!RESET_N_I) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= `RST_ZERO;
			rresp_q   <= `RESP_OKAY;
		end else begin
			if (do_read) begin
				rdata_q   <= rd_val;
				rresp_q   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
				rvalid_q  <= 1'b1;
				arready_q <= 1'b0;
			end else if (rvalid_q && AXI_RREADY_I) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------
	// outputs, all from flip-flops; one bit per line throughout
	// -------------------------------------------------------------------
	assign AXI_AWREADY_O = awready_q;
	assign AXI_WREADY_O  = wready_q;
	assign AXI_BVALID_O  = bvalid_q;
	assign AXI_BRESP_O   = bresp_q;
	assign AXI_ARREADY_O = arready_q;
	assign AXI_RVALID_O  = rvalid_q;
	assign AXI_RDATA_O   = rdata_q;
	assign AXI_RRESP_O   = rresp_q;
	assign PIN_OUT_O     = pin_out_q;
	assign PIN_OE_O      = pin_oe_q;
	assign PULLUP_EN_O   = pullup_en_q;
	assign PERA_IN_O     = pera_in_q;
	assign PERB_IN_O     = perb_in_q;
	assign IRQ_O         = irq_q;

endmodule

/* File: verification/peri_model.sv */
`timescale 1ns/100ps
module peri_model #(
	parameter [31:0] A_OUT = 32'h00000000, // peripheral a levels
	parameter [31:0] A_OE  = 32'h00000000, // peripheral a drive
	parameter [31:0] B_OUT = 32'h00000000, // peripheral b levels
	parameter [31:0] B_OE  = 32'h00000000  // peripheral b drive
) (
	// clock
	input  wire        clk_i,
	// pad side of the controller
	input  wire [31:0] oe_i,
	input  wire [31:0] out_i,
	input  wire [31:0] pu_i,
	output wire [31:0] pin_o,
	// peripheral drive
	output wire [31:0] a_out_o,
	output wire [31:0] a_oe_o,
	output wire [31:0] b_out_o,
	output wire [31:0] b_oe_o
);
	// --------------------------------------------------------------
	// pads: undriven lines rise by pull-up, otherwise never settle
	// --------------------------------------------------------------
	reg [31:0] float_q = 32'h00000000; // toggles so nothing is held

	// a floating unpulled line must not look like a stable level
	always @(posedge clk_i) begin
		float_q <= ~float_q;
	end
	assign pin_o = (oe_i & out_i) | (~oe_i & pu_i)
		| (~oe_i & ~pu_i & float_q);
	// fixed patterns, so each source shows on distinct lines
	assign a_out_o = A_OUT;
	assign a_oe_o  = A_OE;
	assign b_out_o = B_OUT;
	assign b_oe_o  = B_OE;
endmodule

/* File: verification/parallel_io_ctrl_assertions.sv */
`timescale 1ns/100ps
module io_chk (
	// clock, reset, sampling enable
	input wire        REF_CLK_I,
	input wire        RESET_N_I,
	input wire        CLK_EN_I,
	// bus handshakes
	input wire        AXI_AWVALID_I,
	input wire        AXI_AWREADY_O,
	input wire        AXI_WVALID_I,
	input wire        AXI_WREADY_O,
	input wire        AXI_BVALID_O,
	input wire        AXI_BREADY_I,
	input wire [1:0]  AXI_BRESP_O,
	input wire        AXI_ARVALID_I,
	input wire        AXI_ARREADY_O,
	input wire        AXI_RVALID_O,
	input wire        AXI_RREADY_I,
	input wire [31:0] AXI_RDATA_O,
	// pads and peripherals
	input wire [31:0] PIN_IN_I,
	input wire [31:0] PULLUP_EN_O,
	input wire [31:0] PERA_IN_O,
	input wire [31:0] PERB_IN_O,
	input wire        IRQ_O
);
	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	// writes finish with the sampling enable low as well
	chk_b_answer: assert property (
		AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O
		|-> ##[1:2] AXI_BVALID_O) else $error("no write response");
	chk_b_hold: assert property (
		AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O && $stable(AXI_BRESP_O))
		else $error("write response dropped");
	chk_b_done: assert property (
		AXI_BVALID_O && AXI_BREADY_I |=> !AXI_BVALID_O && AXI_AWREADY_O
		&& AXI_WREADY_O) else $error("write channel not reopened");
	chk_w_refuse: assert property (
		AXI_BVALID_O |-> !AXI_AWREADY_O && !AXI_WREADY_O)
		else $error("second write taken");
	chk_r_answer: assert property (
		AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O && !AXI_ARREADY_O)
		else $error("no read data");
	chk_r_hold: assert property (
		AXI_RVALID_O && !AXI_RREADY_I |=> AXI_RVALID_O && $stable(AXI_RDATA_O))
		else $error("read data dropped");
	chk_r_done: assert property (
		AXI_RVALID_O && AXI_RREADY_I |=> !AXI_RVALID_O && AXI_ARREADY_O)
		else $error("read channel not reopened");
	// input reaches both peripherals, one register late
	chk_periph_in: assert property (
		$past(RESET_N_I) |-> PERA_IN_O == $past(PIN_IN_I)
		&& PERB_IN_O == $past(PIN_IN_I)) else $error("peripheral input");
	chk_irq_gated: assert property (
		!CLK_EN_I && $past(CLK_EN_I) == 1'b0 |-> !IRQ_O)
		else $error("interrupt while stopped");
	chk_pullup_reset: assert property (
		$rose(RESET_N_I) |-> PULLUP_EN_O == 32'hFFFFFFFF)
		else $error("pull-ups off after reset");
	cover property (AXI_BVALID_O && AXI_BREADY_I && AXI_BRESP_O == 2'h2);
	cover property ($rose(IRQ_O));
	cover property (AXI_RVALID_O && AXI_RREADY_I && !CLK_EN_I);
endmodule

bind parallel_io_ctrl io_chk u_chk (.REF_CLK_I, .RESET_N_I, .CLK_EN_I,
	.AXI_AWVALID_I, .AXI_AWREADY_O, .AXI_WVALID_I, .AXI_WREADY_O,
	.AXI_BVALID_O, .AXI_BREADY_I, .AXI_BRESP_O, .AXI_ARVALID_I,
	.AXI_ARREADY_O, .AXI_RVALID_O, .AXI_RREADY_I, .AXI_RDATA_O,
	.PIN_IN_I, .PULLUP_EN_O, .PERA_IN_O, .PERB_IN_O, .IRQ_O);

/* File: verification/parallel_io_ctrl_tb.sv */
`timescale 1ns/100ps
`include "pio_ctrl_consts.vh"
module parallel_io_ctrl_tb;
	// --------------------------------------------------------------
	// lines 0-3 plain io, lines 8-15 peripheral-owned from reset
	// --------------------------------------------------------------
	localparam [31:0] MUX  = 32'hFFFFFFF0;
	localparam [31:0] OWNR = 32'hFFFF00FF;
	localparam [31:0] AO   = 32'h5A5A5A5A;
	localparam [31:0] AE   = 32'h00FFFF00;
	localparam [31:0] BO   = 32'hC3C3C3C3;
	localparam [31:0] BE   = 32'hFF0000FF;
	reg         clk, rst_n, clk_en, aw_v, w_v, b_r, ar_v, r_r;
	reg  [7:0]  aw_a, ar_a;
	reg  [31:0] w_d;
	wire        aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
	wire [1:0]  b_rsp, r_rsp;
	wire [31:0] r_d, p_in, p_out, p_oe, pu_en, a_out, a_oe;
	wire [31:0] b_out, b_oe, a_in, b_in;
	// shadow state: register and pad expectations are derived from it
	reg  [31:0] own, sel, oe, dat, wm, md, pu, msk, got, lv, ox, dx;
	integer     n_fail, n_tests;

	parallel_io_ctrl #(.MUX_LINES_P(MUX), .OWN_RESET_P(OWNR)) uut (
		.REF_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(clk_en),
		.AXI_AWVALID_I(aw_v), .AXI_AWREADY_O(aw_rdy), .AXI_AWADDR_I(aw_a),
		.AXI_WVALID_I(w_v), .AXI_WREADY_O(w_rdy), .AXI_WDATA_I(w_d),
		.AXI_WSTRB_I(4'hF), .AXI_BVALID_O(b_v), .AXI_BREADY_I(b_r),
		.AXI_BRESP_O(b_rsp), .AXI_ARVALID_I(ar_v), .AXI_ARREADY_O(ar_rdy),
		.AXI_ARADDR_I(ar_a), .AXI_RVALID_O(r_v), .AXI_RREADY_I(r_r),
		.AXI_RDATA_O(r_d), .AXI_RRESP_O(r_rsp), .PIN_IN_I(p_in),
		.PIN_OUT_O(p_out), .PIN_OE_O(p_oe), .PULLUP_EN_O(pu_en),
		.PERA_OUT_I(a_out), .PERA_OE_I(a_oe), .PERA_IN_O(a_in),
		.PERB_OUT_I(b_out), .PERB_OE_I(b_oe), .PERB_IN_O(b_in),
		.IRQ_O(irq));
	peri_model #(.A_OUT(AO), .A_OE(AE), .B_OUT(BO), .B_OE(BE)) u_peri (
		.clk_i(clk), .oe_i(p_oe), .out_i(p_out), .pu_i(pu_en),
		.pin_o(p_in), .a_out_o(a_out), .a_oe_o(a_oe), .b_out_o(b_out),
		.b_oe_o(b_oe));

	// --------------------------------------------------------------
	// checking and bus tasks
	// --------------------------------------------------------------
	task test_done;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, n_fail);
			if (n_fail == 0 && n_tests > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("ERROR %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// a hung handshake ends the run rather than the simulator
	task guard(input integer k);
		begin
			if (k > 30) begin
				n_fail = n_fail + 1;
				$display("ERROR %0t: bus timeout", $time);
				test_done;
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] r);
		integer k;
		reg     ta, tw, tb;
		begin
			@(posedge clk);
			aw_v <= 1'b1;
			w_v  <= 1'b1;
			aw_a <= a;
			w_d  <= d;
			b_r  <= 1'b1;
			tb = 1'b0;
			for (k = 0; !tb; k = k + 1) begin
				@(negedge clk);
				ta = aw_v & aw_rdy;
				tw = w_v & w_rdy;
				tb = b_v;
				if (tb)
					chk({30'h0, b_rsp}, {30'h0, r});
				@(posedge clk);
				if (ta)
					aw_v <= 1'b0;
				if (tw)
					w_v <= 1'b0;
				if (tb)
					b_r <= 1'b0;
				guard(k);
			end
		end
	endtask
	task rd(input [7:0] a, input [1:0] r, output [31:0] g);
		integer k;
		reg     ta, tr;
		begin
			@(posedge clk);
			ar_v <= 1'b1;
			ar_a <= a;
			r_r  <= 1'b1;
			tr = 1'b0;
			for (k = 0; !tr; k = k + 1) begin
				@(negedge clk);
				ta = ar_v & ar_rdy;
				tr = r_v;
				g = r_d;
				if (tr)
					chk({30'h0, r_rsp}, {30'h0, r});
				@(posedge clk);
				if (ta)
					ar_v <= 1'b0;
				if (tr)
					r_r <= 1'b0;
				guard(k);
			end
		end
	endtask
	task rdc(input [7:0] a, input [31:0] e);
		begin
			rd(a, `RESP_OKAY, got);
			chk(got, e);
		end
	endtask
	// write and follow the effect in the shadow
	task wrs(input [7:0] a, input [31:0] d);
		begin
			wr(a, d, `RESP_OKAY);
			case (a)
				`OFS_OWN_EN:    own = own | d;
				`OFS_OWN_DIS:   own = own & ~d;
				`OFS_OUT_EN:    oe = oe | d;
				`OFS_OUT_DIS:   oe = oe & ~d;
				`OFS_SET_DATA:  dat = dat | d;
				`OFS_CLR_DATA:  dat = dat & ~d;
				`OFS_DATA_STAT: dat = dat & ~wm | d & wm;
				`OFS_MD_EN:     md = md | d;
				`OFS_PU_DIS:    pu = pu | d;
				`OFS_PU_EN:     pu = pu & ~d;
				`OFS_SEL_A:     sel = sel & ~d;
				`OFS_SEL_B:     sel = sel | d;
				`OFS_WM_EN:     wm = wm | d;
				`OFS_WM_DIS:    wm = wm & ~d;
				`OFS_IRQ_EN:    msk = msk | d;
				`OFS_IRQ_DIS:   msk = msk & ~d;
				default:        got = got;
			endcase
			own = own | ~MUX;
		end
	endtask
	// expected pad drive; released lines read high through pull-ups
	task calc;
		begin
			ox = own & oe | ~own & (~sel & AE | sel & BE);
			dx = own & dat | ~own & (~sel & AO | sel & BO);
			ox = ox & ~(md & dx);
			dx = dx & ~md;
			lv = ox & dx | ~ox;
		end
	endtask
	task chk_all;
		begin
			rdc(`OFS_OWN_STAT, own);
			rdc(`OFS_OUT_STAT, oe);
			rdc(`OFS_DATA_STAT, dat);
			rdc(`OFS_SEL_STAT, sel);
			rdc(`OFS_WM_STAT, wm);
			rdc(`OFS_MD_STAT, md);
			rdc(`OFS_PU_STAT, pu);
			calc;
			@(negedge clk);
			chk(p_oe, ox);
			chk(p_out, dx);
			chk(pu_en, ~pu);
		end
	endtask
	task settle(input integer n);
		begin
			repeat (n) @(posedge clk);
			@(negedge clk);
		end
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{rst_n, clk_en, aw_v, w_v, b_r, ar_v, r_r} = 7'h00;
		{aw_a, ar_a, w_d} = 48'h0;
		{sel, oe, dat, wm, md, pu, msk, got} = 256'h0;
		own = OWNR | ~MUX;
		n_fail = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_all;
		$display("test reset values done");
		// sampling stays off here: configuration needs no clock
		wrs(`OFS_OWN_DIS, 32'hFFFFFFFF);
		chk_all;
		wrs(`OFS_SEL_B, 32'hFFFF0000);
		wrs(`OFS_SEL_A, 32'h00F00000);
		chk_all;
		$display("test ownership and choice done");
		wrs(`OFS_OUT_EN, 32'h0000FFFF);
		wrs(`OFS_SET_DATA, 32'h000000AA);
		wrs(`OFS_CLR_DATA, 32'h00000022);
		chk_all;
		wrs(`OFS_OWN_EN, 32'h0000FFF0);
		chk_all;
		$display("test output control done");
		wrs(`OFS_WM_EN, 32'h0000000F);
		wrs(`OFS_DATA_STAT, 32'hFFFFFFFF);
		wrs(`OFS_WM_DIS, 32'h00000001);
		wrs(`OFS_DATA_STAT, 32'h00000000);
		wrs(`OFS_MD_EN, 32'h00000003);
		chk_all;
		$display("test direct write and open drain done");
		wrs(`OFS_PU_DIS, 32'h00F0FF00);
		wrs(`OFS_PU_EN, 32'h00000F00);
		wrs(`OFS_OUT_DIS, 32'h00000000);
		wr(`OFS_OWN_STAT, 32'h00000000, `RESP_SLVERR);
		rd(8'hFC, `RESP_SLVERR, got);
		chk(got, 32'h00000000);
		rdc(`OFS_SET_DATA, 32'h00000000);
		chk_all;
		$display("test pull-ups and access kinds done");
		@(posedge clk);
		clk_en <= 1'b1;
		wrs(`OFS_IRQ_EN, 32'h00000010);
		settle(3);
		rd(`OFS_IRQ_STAT, `RESP_OKAY, got);
		calc;
		rdc(`OFS_PIN_LEVEL, lv);
		settle(2);
		chk({31'h0, irq}, 32'h0);
		wrs(`OFS_SET_DATA, 32'h00000010);
		settle(3);
		chk({31'h0, irq}, 32'h1);
		rdc(`OFS_IRQ_STAT, 32'h00000010);
		settle(2);
		chk({31'h0, irq}, 32'h0);
		calc;
		@(posedge clk);
		clk_en <= 1'b0;
		wrs(`OFS_CLR_DATA, 32'h00000010);
		settle(3);
		chk({31'h0, irq}, 32'h0);
		rdc(`OFS_PIN_LEVEL, lv);
		@(posedge clk);
		clk_en <= 1'b1;
		settle(3);
		chk({31'h0, irq}, 32'h1);
		rdc(`OFS_IRQ_STAT, 32'h00000010);
		wrs(`OFS_IRQ_DIS, 32'h00000010);
		rdc(`OFS_IRQ_MASK, msk);
		$display("test sampling and change flags done");
		test_done;
	end
endmodule
